// ---- ecsea_pkg.sv ----
/*
  Constants shared by the self-checking error analysis translator:
  plane layout, parity-check matrix rows, command word fields and status
  word bit positions.
  Assumes a 16-bit data word, six check planes and four spare planes.
*/
package ecsea_pkg;

  // ==========================================================
  // Plane layout of one stored word
  localparam int ECSEA_DATA_W = 16;
  localparam int ECSEA_CHK_W = 6;
  localparam int ECSEA_CODE_W = 22;
  localparam int ECSEA_SPARE_N = 4;
  localparam int ECSEA_PLANE_W = 26;
  localparam int ECSEA_CHK_LSB = 16;
  localparam int ECSEA_SPARE_LSB = 22;

  // ==========================================================
  // Rows of the odd-weight check matrix, bit i is data bit i
  localparam logic [15:0] ECSEA_ROW [6] = '{
    16'h00FF, 16'h1FE0, 16'h6927, 16'hB259, 16'hDC8A, 16'hE714
  };

  // ==========================================================
  // Command word held in the storage data register
  localparam int ECSEA_CMD_KIND_LSB = 14;
  localparam logic [1:0] ECSEA_CMD_SPARE = 2'h0;
  localparam logic [1:0] ECSEA_CMD_MODE = 2'h1;
  localparam logic [1:0] ECSEA_CMD_FAKE_CB = 2'h2;
  localparam logic [1:0] ECSEA_CMD_CLR_FREEZE = 2'h3;
  localparam int ECSEA_CMD_SPARE_SEL_LSB = 12;
  localparam int ECSEA_CMD_MODE_TEST = 0;
  localparam int ECSEA_CMD_MODE_NOCORR = 1;

  // ==========================================================
  // Error/status word bit positions and reset value
  localparam int ECSEA_ST_NO_ERR = 0;
  localparam int ECSEA_ST_SINGLE = 1;
  localparam int ECSEA_ST_DOUBLE = 2;
  localparam int ECSEA_ST_XLAT = 3;
  localparam int ECSEA_ST_CB_LSB = 4;
  localparam int ECSEA_ST_WR_PAR = 10;
  localparam int ECSEA_ST_N_DOUBLE = 12;
  localparam int ECSEA_ST_N_XLAT = 13;
  localparam logic [15:0] ECSEA_STATUS_RST = 16'h0000;

endpackage

// ---- ecsea_dr_parity.sv ----
/*
  Split parity tree with a dual-rail (morphic) output.
  Assumes the caller reads the pair as one value when the rails differ;
  a fault inside one half disturbs only one rail.
*/
`timescale 1ns/1ps
module ecsea_dr_parity #(
  parameter int N = 9
) (
  input wire logic [N-1:0] bits,
  output logic [1:0] pair
);
  // ==========================================================
  // Two independent partial trees, one per rail
  always_comb begin
    pair[0] = ^bits[N/2-1:0];
    pair[1] = ^bits[N-1:N/2];
  end
endmodule

// ---- ecsea_spare_decode.sv ----
/*
  Decodes one spare assignment pattern into a one-hot plane select.
  Assumes the pattern is a column of the check matrix; any other pattern,
  including all zero, selects nothing.
*/
`timescale 1ns/1ps
module ecsea_spare_decode
  import ecsea_pkg::*;
(
  input wire logic [5:0] pattern,
  output logic [ECSEA_CODE_W-1:0] sel
);
  // ==========================================================
  // Match the pattern against every data and check column
  always_comb begin
    logic [5:0] col;
    col = 6'h00;
    sel = '0;
    for (int i = 0; i < ECSEA_DATA_W; i++) begin
      for (int r = 0; r < ECSEA_CHK_W; r++) begin
        col[r] = ECSEA_ROW[r][i];
      end
      sel[i] = (pattern == col); // RULE_22
    end
    for (int k = 0; k < ECSEA_CHK_W; k++) begin
      sel[ECSEA_CHK_LSB+k] = (pattern == 6'(1 << k)); // RULE_22
    end
    if (pattern == 6'h00) begin
      sel = '0; // RULE_24
    end
  end
endmodule

// ---- ecsea_translator.sv ----
/*
  Error analysis, command and status section of a memory translator.
  Assumes memory cycles and command strobes are single-cycle pulses
  synchronous to mclk and never overlap; the partner microcode honours
  the storage address freeze output.
*/
// Operation
// RULE_01 - Every analysis signal travels as rail pair
// RULE_02 - A: dual-rail AND of six syndromes
// RULE_03 - B: two rail parity trees, byte parity blocked
// RULE_04 - No error when A one, B zero
// RULE_05 - A and B both one: circuit failure
// RULE_06 - Single error: A zero, B one
// RULE_07 - Double error: A zero, B zero
// RULE_08 - Circuit check ANDs four normally-one inputs
// RULE_09 - Byte parity plus check bits parity even
// RULE_10 - Single error valid only with consistency
// RULE_11 - Exactly one outcome flag, else failure
// RULE_12 - Command strobe loads storage data register
// RULE_13 - Four command kinds decoded
// RULE_14 - Spare command loads spare assignment register
// RULE_15 - Fake check bits replace generated on stores
// RULE_16 - Double error freezes address until cleared
// RULE_17 - Mode command selects test and diagnostics
// RULE_18 - Status bits 0-3 test-mode read results
// RULE_19 - Status bits 4-9 check bits read
// RULE_20 - Bits 10,12,13 write/normal errors; others spare
// RULE_21 - Four spare assignment registers hold syndromes
// RULE_22 - Decoded pattern swaps spare plane in
// RULE_23 - Syndromes: odd parity over nine-bit fields
// RULE_24 - Zero pattern means spare unassigned
// RULE_25 - Status held until next cycle overwrites
`timescale 1ns/1ps
module ecsea_translator
  import ecsea_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic mem_rd,
  input wire logic [ECSEA_PLANE_W-1:0] rd_planes,
  input wire logic mem_wr,
  input wire logic [ECSEA_DATA_W-1:0] wr_data,
  input wire logic [1:0] wr_byte_par,
  input wire logic translator_command_op,
  input wire logic [15:0] storage_data_reg,
  output logic [ECSEA_PLANE_W-1:0] wr_planes,
  output logic [ECSEA_CODE_W-1:0] rd_word,
  output logic rd_done,
  output logic wr_done,
  output logic no_error,
  output logic single_error,
  output logic double_error,
  output logic circuit_error,
  output logic storage_address_freeze,
  output logic test_mode,
  output logic inhibit_correct,
  output logic [15:0] translator_error_status_word
);

  // ==========================================================
  // State of the block as one record
  typedef struct packed {
    logic [15:0] cmd;
    logic test;
    logic nocorr;
    logic fake_en;
    logic [5:0] fake_cb;
    logic [3:0][5:0] spare;
    logic freeze;
    logic [15:0] status;
    logic [ECSEA_PLANE_W-1:0] wr_planes;
    logic [ECSEA_CODE_W-1:0] rd_word;
    logic rd_done;
    logic wr_done;
    logic no_err;
    logic single;
    logic dbl;
    logic cerr;
  } ecsea_state_t;

  ecsea_state_t st_q;
  ecsea_state_t st_d;

  // ==========================================================
  // Dual-rail helpers: value is the XOR of the rails
  function automatic logic dr_val(input logic [1:0] p);
    dr_val = p[1] ^ p[0];
  endfunction

  // Phase taken from an input so both rails keep toggling
  function automatic logic [1:0] dr_mk(input logic v, input logic ph);
    dr_mk = {ph, v ^ ph};
  endfunction

  function automatic logic [1:0] dr_not(input logic [1:0] p);
    dr_not = {p[1], ~p[0]};
  endfunction

  function automatic logic [1:0] dual_rail_and(input logic [1:0] x, input logic [1:0] y);
    dual_rail_and = dr_mk(dr_val(x) & dr_val(y), x[1]);
  endfunction

  // ==========================================================
  // Spare plane substitution on the read path
  logic [3:0][ECSEA_CODE_W-1:0] spare_sel;
  logic [ECSEA_CODE_W-1:0] code_rd;

  for (genvar k = 0; k < ECSEA_SPARE_N; k++) begin : g_spare
    ecsea_spare_decode u_dec (
      .pattern(st_q.spare[k]),
      .sel(spare_sel[k])
    );
  end

  // Later spare wins if microcode ever assigns two to one bit
  always_comb begin
    code_rd = rd_planes[ECSEA_CODE_W-1:0];
    for (int k = 0; k < ECSEA_SPARE_N; k++) begin
      for (int j = 0; j < ECSEA_CODE_W; j++) begin
        if (spare_sel[k][j]) begin
          code_rd[j] = rd_planes[ECSEA_SPARE_LSB+k]; // RULE_22
        end
      end
    end
  end

  // ==========================================================
  // Syndrome trees over data field and its check bit
  logic [5:0][8:0] field;
  logic [5:0][1:0] syn;

  for (genvar r = 0; r < ECSEA_CHK_W; r++) begin : g_syn
    always_comb begin
      int n;
      n = 0;
      field[r] = '0;
      for (int i = 0; i < ECSEA_DATA_W; i++) begin
        if (ECSEA_ROW[r][i]) begin
          field[r][n[2:0]] = code_rd[i];
          n = n + 1;
        end
      end
      field[r][8] = code_rd[ECSEA_CHK_LSB+r];
    end
    ecsea_dr_parity #(.N(9)) u_syn (
      .bits(field[r]), // RULE_23
      .pair(syn[r])
    );
  end

  // ==========================================================
  // Check bit generation and byte parity for both cycle kinds
  logic [ECSEA_DATA_W-1:0] data_in;
  logic [5:0] gen_cb;
  logic [1:0] byte_par;

  always_comb begin
    data_in = mem_rd ? code_rd[ECSEA_DATA_W-1:0] : wr_data;
    for (int r = 0; r < ECSEA_CHK_W; r++) begin
      gen_cb[r] = ~^(data_in & ECSEA_ROW[r]);
    end
    // On reads the byte parity is regenerated from the data
    byte_par = mem_rd ? {~^data_in[15:8], ~^data_in[7:0]} : wr_byte_par;
  end

  // ==========================================================
  // Morphic error analysis network
  logic [1:0] sig_a;
  logic [1:0] sig_b;
  logic [1:0] sig_p;
  logic [1:0] sig_q;
  logic [1:0] sig_r;
  logic [1:0] sig_s;
  logic [1:0] sig_t;
  logic [1:0] sig_u;
  logic [1:0] sig_tr;
  logic [1:0] sig_prs;
  logic [1:0] sig_d;
  logic [1:0] t_raw;
  logic [1:0] u_raw;
  logic [1:0] gated_bp;
  logic [7:0] t_bits;
  logic [17:0] u_bits;

  always_comb begin
    sig_a = syn[0];
    for (int r = 1; r < ECSEA_CHK_W; r++) begin
      sig_a = dual_rail_and(sig_a, syn[r]); // RULE_02
    end
    // Byte parity inputs are held out of the B trees on reads
    gated_bp = mem_rd ? 2'h0 : byte_par; // RULE_03
    sig_b[0] = ^{gated_bp[0], syn[0][0], syn[1][0], syn[2][0], syn[3][0], syn[4][0], syn[5][0]};
    sig_b[1] = ^{gated_bp[1], syn[0][1], syn[1][1], syn[2][1], syn[3][1], syn[4][1], syn[5][1]};
    if (!mem_rd) begin
      sig_b[1] = sig_b[1] ^ gated_bp[0] ^ gated_bp[1] ^ 1'b1;
    end
    sig_p = dual_rail_and(sig_a, dr_not(sig_b)); // RULE_04
    sig_q = dual_rail_and(sig_a, sig_b); // RULE_05
    sig_r = dual_rail_and(dr_not(sig_a), sig_b); // RULE_06
    sig_s = dual_rail_and(dr_not(sig_a), dr_not(sig_b)); // RULE_07
    // Combined parity of byte parity and check bits must be even
    t_bits = {byte_par, mem_wr ? (st_q.fake_en ? st_q.fake_cb : gen_cb) : gen_cb};
    t_raw = {^t_bits[7:4], ^t_bits[3:0]};
    sig_t = dr_not(t_raw); // RULE_09
    // Single error only trusted alongside a consistent code
    sig_tr = dual_rail_and(sig_t, dr_mk(~dr_val(sig_r) | dr_val(sig_t), sig_r[1])); // RULE_10
    // Byte parity check: each byte plus its bit must be odd
    u_bits = {byte_par[1], data_in[15:8], byte_par[0], data_in[7:0]};
    u_raw = {^u_bits[17:9], ^u_bits[8:0]};
    sig_u = dr_mk(dr_val(u_raw[1:1] == 1'b1 ? 2'h1 : 2'h0) & u_raw[0], u_raw[1]);
    // Odd count of P, R, S means exactly one outcome
    sig_prs = {dr_val(sig_p) ^ dr_val(sig_r), dr_val(sig_s)}; // RULE_11
    sig_d = dual_rail_and(dual_rail_and(sig_u, dr_not(sig_q)),
      dual_rail_and(sig_tr, sig_prs)); // RULE_08
    // Stores judge only byte parity and code consistency; the syndrome
    // network is looking at stale read planes then and would give false alarms
    if (!mem_rd) begin
      sig_d = dual_rail_and(sig_u, sig_t); // RULE_20
    end
  end

  // ==========================================================
  // Next-state: commands, memory cycles, status capture
  always_comb begin
    logic [1:0] kind;
    logic cerr;
    logic rd_cerr;
    logic [5:0] cb_out;
    kind = 2'h0;
    cerr = 1'b0;
    rd_cerr = 1'b0;
    cb_out = 6'h00;
    st_d = st_q;
    st_d.rd_done = 1'b0;
    st_d.wr_done = 1'b0;
    cerr = ~dr_val(sig_d); // RULE_01
    if (translator_command_op) begin
      st_d.cmd = storage_data_reg; // RULE_12
      kind = storage_data_reg[ECSEA_CMD_KIND_LSB +: 2];
      unique case (kind) // RULE_13
        ECSEA_CMD_SPARE: begin
          st_d.spare[storage_data_reg[ECSEA_CMD_SPARE_SEL_LSB +: 2]] =
            storage_data_reg[5:0]; // RULE_14 RULE_21
        end
        ECSEA_CMD_MODE: begin
          st_d.test = storage_data_reg[ECSEA_CMD_MODE_TEST]; // RULE_17
          st_d.nocorr = storage_data_reg[ECSEA_CMD_MODE_NOCORR];
          st_d.fake_en = 1'b0;
        end
        ECSEA_CMD_FAKE_CB: begin
          st_d.fake_cb = storage_data_reg[5:0]; // RULE_15
          st_d.fake_en = 1'b1;
        end
        ECSEA_CMD_CLR_FREEZE: begin
          st_d.freeze = 1'b0; // RULE_16
        end
      endcase
    end
    if (mem_rd) begin
      rd_cerr = cerr;
      st_d.rd_word = code_rd;
      st_d.rd_done = 1'b1;
      st_d.no_err = dr_val(sig_p) & ~cerr;
      st_d.single = dr_val(sig_r) & ~cerr;
      st_d.dbl = dr_val(sig_s) & ~cerr;
      st_d.cerr = cerr;
      st_d.status = ECSEA_STATUS_RST; // RULE_25
      st_d.status[ECSEA_ST_CB_LSB +: 6] = rd_planes[ECSEA_CHK_LSB +: 6]; // RULE_19
      if (st_q.test) begin
        st_d.status[ECSEA_ST_NO_ERR] = st_d.no_err; // RULE_18
        st_d.status[ECSEA_ST_SINGLE] = st_d.single;
        st_d.status[ECSEA_ST_DOUBLE] = st_d.dbl;
        st_d.status[ECSEA_ST_XLAT] = rd_cerr;
      end else begin
        st_d.status[ECSEA_ST_N_DOUBLE] = st_d.dbl; // RULE_20
        st_d.status[ECSEA_ST_N_XLAT] = rd_cerr;
      end
      // Set wins over a clear command in the same cycle
      if (dr_val(sig_s)) begin
        st_d.freeze = 1'b1; // RULE_16
      end
    end else if (mem_wr) begin
      cb_out = st_q.fake_en ? st_q.fake_cb : gen_cb; // RULE_15
      st_d.wr_planes[ECSEA_DATA_W-1:0] = wr_data;
      st_d.wr_planes[ECSEA_CHK_LSB +: 6] = cb_out;
      // Each assigned spare plane stores the bit it stands in for
      for (int k = 0; k < ECSEA_SPARE_N; k++) begin
        st_d.wr_planes[ECSEA_SPARE_LSB+k] = 1'b0;
        for (int j = 0; j < ECSEA_CODE_W; j++) begin
          if (spare_sel[k][j]) begin
            st_d.wr_planes[ECSEA_SPARE_LSB+k] = st_d.wr_planes[j]; // RULE_22
          end
        end
      end
      st_d.wr_done = 1'b1;
      st_d.status = ECSEA_STATUS_RST;
      st_d.status[ECSEA_ST_WR_PAR] = cerr; // RULE_20
      st_d.cerr = cerr;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs straight from the state record
  assign wr_planes = st_q.wr_planes;
  assign rd_word = st_q.rd_word;
  assign rd_done = st_q.rd_done;
  assign wr_done = st_q.wr_done;
  assign no_error = st_q.no_err;
  assign single_error = st_q.single;
  assign double_error = st_q.dbl;
  assign circuit_error = st_q.cerr;
  assign storage_address_freeze = st_q.freeze;
  assign test_mode = st_q.test;
  assign inhibit_correct = st_q.nocorr;
  assign translator_error_status_word = st_q.status;

endmodule

// ---- ecsea_translator_chk.sv ----
/*
  Concurrent checks on the ports of ecsea_translator, bound below.
  Assumes a single mclk domain with rstn as its asynchronous reset.
*/
`timescale 1ns/1ps
module ecsea_translator_chk
  import ecsea_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic mem_rd,
  input wire logic [ECSEA_PLANE_W-1:0] rd_planes,
  input wire logic mem_wr,
  input wire logic [ECSEA_DATA_W-1:0] wr_data,
  input wire logic [1:0] wr_byte_par,
  input wire logic translator_command_op,
  input wire logic [15:0] storage_data_reg,
  input wire logic [ECSEA_PLANE_W-1:0] wr_planes,
  input wire logic [ECSEA_CODE_W-1:0] rd_word,
  input wire logic rd_done,
  input wire logic wr_done,
  input wire logic no_error,
  input wire logic single_error,
  input wire logic double_error,
  input wire logic circuit_error,
  input wire logic storage_address_freeze,
  input wire logic test_mode,
  input wire logic inhibit_correct,
  input wire logic [15:0] translator_error_status_word
);
  logic [15:0] sw;
  logic [1:0] kind;

  // ==========================================================
  // Shorthands; reset masks every check
  assign sw = translator_error_status_word;
  assign kind = storage_data_reg[15:14];
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rstn);

  // ==========================================================
  // Steps of a read and of a freeze release
  sequence s_dbl_read;
    mem_rd ##1 (rd_done && double_error);
  endsequence
  sequence s_clr_cmd;
    translator_command_op && kind == ECSEA_CMD_CLR_FREEZE && !mem_rd;
  endsequence

  a_rd_answer: assert property (mem_rd |=> rd_done)
    else $error("read cycle got no done pulse");
  a_wr_answer: assert property (mem_wr && !mem_rd |=> wr_done && !rd_done)
    else $error("write cycle got no done pulse");
  a_flag_onehot: assert property (rd_done && !circuit_error
    |-> $onehot({no_error, single_error, double_error}))
    else $error("outcome flags not exclusive");
  a_freeze_set: assert property (s_dbl_read |-> storage_address_freeze)
    else $error("double error did not freeze address");
  a_freeze_clr: assert property (s_clr_cmd |=> !storage_address_freeze)
    else $error("freeze not released by command");
  a_freeze_hold: assert property (storage_address_freeze
    && !(translator_command_op && kind == ECSEA_CMD_CLR_FREEZE)
    |=> storage_address_freeze)
    else $error("freeze dropped without command");
  a_mode_load: assert property (translator_command_op && kind == ECSEA_CMD_MODE
    |=> test_mode == $past(storage_data_reg[0]) && inhibit_correct == $past(storage_data_reg[1]))
    else $error("mode command not applied");
  a_status_cb: assert property (rd_done |-> sw[9:4] == $past(rd_planes[21:16]))
    else $error("status check bits differ from read");
  a_status_test: assert property (rd_done && test_mode
    |-> {sw[13:12], sw[3:0]} == {2'h0, circuit_error, double_error, single_error, no_error})
    else $error("test mode status wrong");
  a_status_norm: assert property (rd_done && !test_mode
    |-> {sw[13:12], sw[3:0]} == {circuit_error, double_error, 4'h0})
    else $error("normal mode status wrong");
  a_status_wr: assert property (wr_done |-> sw == {5'h0, circuit_error, 10'h0})
    else $error("write status wrong");
  a_status_hold: assert property (!rd_done && !wr_done |-> $stable(sw))
    else $error("status changed without a cycle");
endmodule

bind ecsea_translator ecsea_translator_chk ecsea_translator_chk_inst (.*);

// ---- ecsea_store_model.sv ----
/*
  Stand-in for the plane array and the CPU address register.
  Assumes the bench supplies the fault mask and address requests.
*/
`timescale 1ns/1ps
module ecsea_store_model
  import ecsea_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic wr_done,
  input wire logic [ECSEA_PLANE_W-1:0] wr_planes,
  input wire logic [ECSEA_PLANE_W-1:0] flip,
  input wire logic load_addr,
  input wire logic [7:0] addr_in,
  input wire logic storage_address_freeze,
  output logic [ECSEA_PLANE_W-1:0] rd_planes,
  output logic [7:0] addr_q
);
  logic [ECSEA_PLANE_W-1:0] word_q;

  // ==========================================================
  // Faults are injected on the way out, the stored word stays clean
  assign rd_planes = word_q ^ flip;

  // One stored word; address reload blocked while frozen
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      word_q <= '0;
      addr_q <= '0;
    end else begin
      if (wr_done) word_q <= wr_planes;
      if (load_addr && !storage_address_freeze) addr_q <= addr_in;
    end
  end
endmodule

// ---- ecsea_translator_test.sv ----
/*
  Self-checking bench for ecsea_translator with a store stand-in.
  Assumes mclk at 40 MHz and the package matrix and command layout.
*/
`timescale 1ns/1ps
module ecsea_translator_test
  import ecsea_pkg::*;
;
  logic mclk, rstn, mem_rd, mem_wr, translator_command_op, load_addr;
  logic [15:0] wr_data, storage_data_reg, translator_error_status_word;
  logic [1:0] wr_byte_par;
  logic [7:0] addr_in, addr_q, la;
  logic [25:0] rd_planes, wr_planes, flip, mem_w;
  logic [21:0] rd_word;
  logic rd_done, wr_done, no_error, single_error, double_error, circuit_error;
  logic storage_address_freeze, test_mode, inhibit_correct;
  logic tm, ic, fk, fz;
  logic [5:0] fv;
  logic [31:0] rs;
  int num_errors, check_count, cyc_n, sp[4];

  ecsea_translator ecsea_translator_inst (.mclk, .rstn, .mem_rd, .rd_planes, .mem_wr,
    .wr_data, .wr_byte_par, .translator_command_op, .storage_data_reg, .wr_planes,
    .rd_word, .rd_done, .wr_done, .no_error, .single_error, .double_error,
    .circuit_error, .storage_address_freeze, .test_mode, .inhibit_correct,
    .translator_error_status_word);
  ecsea_store_model ecsea_store_model_inst (.mclk, .rstn, .wr_done, .wr_planes, .flip,
    .load_addr, .addr_in, .storage_address_freeze, .rd_planes, .addr_q);

  // ==========================================================
  // Clock and hang guard
  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ==========================================================
  // Reference helpers
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Syndrome column of one code position
  function automatic logic [5:0] col(int j);
    logic [5:0] c;
    for (int r = 0; r < 6; r++) c[r] = (j < 16) ? ECSEA_ROW[r][j] : (j - 16 == r);
    return c;
  endfunction
  function automatic logic [5:0] gen(logic [15:0] d);
    logic [5:0] c;
    for (int r = 0; r < 6; r++) c[r] = ~^(ECSEA_ROW[r] & d);
    return c;
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // One strobe held until its taking edge; k 0 read, 1 write, 2 command
  task automatic op(int k, logic [25:0] v);
    @(posedge mclk);
    mem_rd <= (k == 0);
    mem_wr <= (k == 1);
    translator_command_op <= (k == 2);
    if (k == 0) flip <= v;
    if (k == 1) {wr_byte_par, wr_data} <= v[17:0];
    if (k == 2) storage_data_reg <= v[15:0];
    @(posedge mclk);
    {mem_rd, mem_wr, translator_command_op} <= 3'h0;
    #1;
  endtask
  // Store with optional byte parity fault
  task automatic wr_chk(logic [15:0] d, logic bad);
    logic [1:0] bp;
    logic [25:0] e;
    bp = {~^d[15:8], ~^d[7:0] ^ bad};
    e = {4'h0, fk ? fv : gen(d), d};
    for (int i = 0; i < 4; i++) if (sp[i] >= 0) e[22 + i] = e[sp[i]];
    op(1, {8'h0, bp, d});
    chk(wr_planes, e);
    if (!fk) chk(circuit_error, bad);
    if (!fk) chk(translator_error_status_word, {bad, 10'h0});
    mem_w = e;
  endtask
  // Fetch the stored word through a fault mask
  task automatic rd_chk(logic [25:0] f);
    logic [25:0] p;
    logic [21:0] w;
    logic [3:0] fl;
    int nf;
    p = mem_w ^ f;
    w = p[21:0];
    for (int i = 0; i < 4; i++) if (sp[i] >= 0) w[sp[i]] = p[22 + i];
    nf = 0;
    for (int r = 0; r < 6; r++) nf += !(^(ECSEA_ROW[r] & w[15:0]) ^ w[16 + r]);
    fl = {1'b0, nf > 0 && nf % 2 == 0, nf % 2 == 1, nf == 0};
    fz |= fl[2];
    op(0, f);
    chk(rd_word, w);
    chk({circuit_error, double_error, single_error, no_error}, fl);
    chk(translator_error_status_word,
        tm ? {p[21:16], fl} : {fl[3:2], 2'h0, p[21:16], 4'h0});
    chk(storage_address_freeze, fz);
  endtask
  task automatic cmd(logic [15:0] c);
    case (c[15:14])
      ECSEA_CMD_SPARE: begin
        sp[c[13:12]] = -1;
        for (int j = 0; j < 22; j++) if (c[5:0] == col(j)) sp[c[13:12]] = j;
      end
      ECSEA_CMD_MODE: {fk, ic, tm} = {1'b0, c[1:0]};
      ECSEA_CMD_FAKE_CB: {fk, fv} = {1'b1, c[5:0]};
      default: fz = 0;
    endcase
    op(2, {10'h0, c});
    chk({storage_address_freeze, inhibit_correct, test_mode}, {fz, ic, tm});
  endtask
  task automatic ld(logic [7:0] a, logic [7:0] e);
    @(posedge mclk);
    load_addr <= 1;
    addr_in <= a;
    @(posedge mclk);
    load_addr <= 0;
    #1;
    chk(addr_q, e);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {rstn, mem_rd, mem_wr, translator_command_op, load_addr} = 5'h0;
    {wr_data, wr_byte_par, storage_data_reg, addr_in, flip, la} = '0;
    {tm, ic, fk, fz, fv} = '0;
    sp = '{-1, -1, -1, -1};
    rs = 32'hA5F3A022;
    repeat (6) @(posedge mclk);
    rstn <= 1;
    #1;
    chk(translator_error_status_word, ECSEA_STATUS_RST);
    // Random words with none, single, double and scattered faults
    for (int i = 1; i < 17; i++) begin
      rs = lfsr(rs);
      wr_chk(rs[15:0], 0);
      case (i % 4)
        0: rd_chk(26'h0);
        1: rd_chk(26'h1 << rs[19:16]);
        2: rd_chk((26'h1 << rs[19:16]) | (26'h10000 << (i % 6)));
        default: rd_chk({4'h0, rs[31:10]});
      endcase
      if (fz) begin
        ld(8'(i), la);
        cmd(16'hC000);
        ld(8'(i), 8'(i));
        la = 8'(i);
      end
    end
    // Byte parity fault on a store, then test mode reads
    wr_chk(16'h5A3C, 1);
    cmd(16'h4001);
    rd_chk(26'h0);
    rd_chk(26'h8);
    rd_chk(26'h30000);
    cmd(16'hC000);
    cmd(16'h4002);
    // Fake check bits until the next mode command
    cmd(16'h802A);
    wr_chk(16'h1234, 0);
    cmd(16'h4000);
    wr_chk(16'h1234, 0);
    // Spare plane 1 replaces data bit 5, then is unassigned
    cmd({4'h1, 6'h0, col(5)});
    wr_chk(16'hBEEF, 0);
    rd_chk(26'h20);
    rd_chk(26'h800000);
    cmd(16'h1000);
    rd_chk(26'h20);
    wrap_up();
  end
endmodule
